// file: hw/tlsr_pkg.sv
// Package: offsets, field layout, reset values and enums for the limit status bank
package tlsr_pkg;

    // Register offsets on the register port
    localparam logic [7:0] ADDR_OVER_HIGH = 8'h35;
    localparam logic [7:0] ADDR_UNDER_LOW = 8'h36;
    localparam logic [7:0] ADDR_CRITICAL = 8'h37;
    localparam logic [7:0] ADDR_AVG_CFG = 8'h40;
    localparam logic [7:0] ADDR_PART_ID = 8'hFD;
    localparam logic [7:0] ADDR_MAKER_ID = 8'hFE;
    localparam logic [7:0] ADDR_REVISION = 8'hFF;

    // Flag bit positions within the three flag registers
    localparam int EXT_BIT = 1;
    localparam int INT_BIT = 0;
    localparam int CHAN_NUM = 2;

    // Averaging field position and width
    localparam int AVG_LSB = 0;
    localparam int AVG_W = 2;

    // Reset values
    localparam logic [1:0] FLAGS_RST = 2'h0;
    localparam logic [1:0] AVG_CFG_RST = 2'h0;
    localparam logic [7:0] RDDATA_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Consecutive counter width, enough for a count of four
    localparam int CNT_W = 3;
    localparam logic [2:0] CNT_RST = 3'h0;

    // Decoded averaging level
    typedef enum logic [1:0]
    {
        AVG_OFF = 2'b00,
        AVG_LEVEL1 = 2'b01,
        AVG_LEVEL2 = 2'b10
    } tlsr_avg_e;

    // Count setting decode: one more than the number of set bits
    function automatic logic [2:0] tlsr_count_need(input logic [2:0] setting);
        logic [2:0] n;
        n = 3'h1;
        n = n + {2'h0, setting[0]} + {2'h0, setting[1]} + {2'h0, setting[2]};
        return n;
    endfunction

endpackage

// file: hw/temp_limit_status_regs.sv
// Limit status flags, summaries, averaging setting and identification registers
`timescale 1ns/1ps
`default_nettype none

// Function
// - Over-high flags: ext bit 1, int bit 0
// - Any over-high flag sets high summary
// - Reading over-high clears flags and summary, outside comparator mode only
// - Event output needs count reached plus flag
// - Flags latch until read; comparator follows live
// - Under-low flags: ext bit 1, int bit 0
// - Under-low summary; read clears flags and summary outside comparator mode
// - Critical flags per channel set summary bit
// - Reading critical flags has no side effect
// - Critical flag clears below limit minus hysteresis
// - Critical summary clears when all flags clear
// - Averaging config field, reset zero, external only
// - Decode 00 off, 01/10 level1, 11 level2
// - Fixed read-only part code, writes ignored
// - Fixed read-only maker code
// - Revision code selectable between two values
// - Comparator event holds until below high-hysteresis
// - Mask blocks event output, not shutdown
// - Count setting decodes to one..four measurements
module temp_limit_status_regs #(
    parameter logic [7:0] PART_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
    parameter logic [7:0] REV_CODE_A = 8'h11, // Arbitrary value
    parameter logic [7:0] REV_CODE_B = 8'h12, // Arbitrary value
    parameter bit REV_SEL_B = 1'b0
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Configuration from neighbouring units, same clock
    input wire logic comparatorMode,
    input wire logic [2:0] eventCountSetting,
    input wire logic extEventSuppress,
    input wire logic intEventSuppress,
    // Conversion side, own clock
    input wire logic convClk,
    input wire logic convRst,
    input wire logic measValid,
    input wire logic [1:0] overHigh,
    input wire logic [1:0] underLow,
    input wire logic [1:0] overCrit,
    input wire logic [1:0] belowCritHyst,
    input wire logic [1:0] belowHighHyst,
    // Outputs
    output logic eventOutN,
    output logic shutdownOutN,
    output logic highSummary,
    output logic lowSummary,
    output logic critSummary,
    output tlsr_pkg::tlsr_avg_e extAvgLevel
);

    localparam int CMP_W = 10;

    // Conversion-domain state
    typedef struct packed {
        logic [CMP_W-1:0] held;
        logic pending;
        logic toggle;
    } tlsr_link_s;

    // System-domain state
    typedef struct packed {
        logic tog1;
        logic tog2;
        logic togSeen;
        logic [CMP_W-1:0] dat1;
        logic [CMP_W-1:0] dat2;
        logic [1:0] highFlags;
        logic [1:0] lowFlags;
        logic [1:0] critFlags;
        logic [1:0] reached;
        logic [2*tlsr_pkg::CNT_W-1:0] cnt;
        logic [1:0] avgCfg;
        logic [7:0] rdData;
        logic eventActive;
        logic shutActive;
        logic highSum;
        logic lowSum;
        logic critSum;
    } tlsr_sys_s;

    tlsr_link_s link_r;
    tlsr_link_s link_nxt;
    tlsr_sys_s sys_r;
    tlsr_sys_s sys_nxt;

    // Capture the comparison set, then toggle a cycle later so the data
    // is stable before the far side can see the toggle move
    // Limitation: a second result within about one link period plus a few
    // system cycles overwrites the held set before it has been taken
    always_comb
    begin
        link_nxt = link_r;
        if (measValid)
        begin
            link_nxt.held = {belowHighHyst, belowCritHyst, overCrit, underLow, overHigh};
            link_nxt.pending = 1'b1;
        end
        else if (link_r.pending)
        begin
            link_nxt.pending = 1'b0;
            link_nxt.toggle = ~link_r.toggle;
        end
    end

    // Conversion-domain registers
    always_ff @(posedge convClk)
    begin
        if (convRst)
        begin
            link_r <= '0;
        end
        else
        begin
            link_r <= link_nxt;
        end
    end

    // Unpacked views of the synchronised comparison set
    logic measEvt;
    logic [1:0] sOverHigh;
    logic [1:0] sUnderLow;
    logic [1:0] sOverCrit;
    logic [1:0] sBelowCritHyst;
    logic [1:0] sBelowHighHyst;
    logic [1:0] suppress;
    logic [2:0] need;
    logic rdHigh;
    logic rdLow;

    // Only the second sync stage is looked at
    // Data moves a link period ahead of the toggle, so it is settled here
    assign measEvt = sys_r.tog2 ^ sys_r.togSeen;
    assign sOverHigh = sys_r.dat2[1:0];
    assign sUnderLow = sys_r.dat2[3:2];
    assign sOverCrit = sys_r.dat2[5:4];
    assign sBelowCritHyst = sys_r.dat2[7:6];
    assign sBelowHighHyst = sys_r.dat2[9:8];
    assign suppress = {extEventSuppress, intEventSuppress};
    assign need = tlsr_pkg::tlsr_count_need(eventCountSetting);
    assign rdHigh = regRdEn && (regAddr == tlsr_pkg::ADDR_OVER_HIGH);
    assign rdLow = regRdEn && (regAddr == tlsr_pkg::ADDR_UNDER_LOW);

    // Flag, counter and register update
    always_comb
    begin
        logic [2:0] c;
        logic [2:0] inc;
        logic outLim;
        c = 3'h0;
        inc = 3'h0;
        outLim = 1'b0;
        sys_nxt = sys_r;
        sys_nxt.tog1 = link_r.toggle;
        sys_nxt.tog2 = sys_r.tog1;
        sys_nxt.togSeen = sys_r.tog2;
        sys_nxt.dat1 = link_r.held;
        sys_nxt.dat2 = sys_r.dat1;

        // In comparator mode the flags mirror the live condition, so a
        // clearing read would only fake a quiet state until the next result
        // Read clears come first so a same-cycle set overrides them
        if (!comparatorMode)
        begin
            if (rdHigh)
            begin
                sys_nxt.highFlags = tlsr_pkg::FLAGS_RST;
            end
            if (rdLow)
            begin
                sys_nxt.lowFlags = tlsr_pkg::FLAGS_RST;
            end
        end
        // Critical flags are untouched by any read

        if (measEvt)
        begin
            for (int ch = 0; ch < tlsr_pkg::CHAN_NUM; ch++)
            begin
                c = sys_r.cnt[ch*tlsr_pkg::CNT_W +: tlsr_pkg::CNT_W];
                inc = c + 3'h1;
                if (comparatorMode)
                begin
                    // Low flags follow the live reading
                    sys_nxt.lowFlags[ch] = sUnderLow[ch];
                    if (sBelowHighHyst[ch])
                    begin
                        sys_nxt.highFlags[ch] = 1'b0;
                        sys_nxt.reached[ch] = 1'b0;
                        c = tlsr_pkg::CNT_RST;
                    end
                    else if (sOverHigh[ch])
                    begin
                        // Counter holds once reached, not reset
                        if (!sys_r.reached[ch])
                        begin
                            c = inc;
                        end
                        if (c >= need)
                        begin
                            sys_nxt.reached[ch] = 1'b1;
                            sys_nxt.highFlags[ch] = 1'b1;
                        end
                    end
                    else if (!sys_r.reached[ch])
                    begin
                        c = tlsr_pkg::CNT_RST;
                    end
                end
                else
                begin
                    sys_nxt.reached[ch] = 1'b0;
                    outLim = sOverHigh[ch] | sUnderLow[ch];
                    if (!outLim)
                    begin
                        c = tlsr_pkg::CNT_RST;
                    end
                    else if (inc >= need)
                    begin
                        // Latch the failing conditions, restart the count
                        if (sOverHigh[ch])
                        begin
                            sys_nxt.highFlags[ch] = 1'b1;
                        end
                        if (sUnderLow[ch])
                        begin
                            sys_nxt.lowFlags[ch] = 1'b1;
                        end
                        c = tlsr_pkg::CNT_RST;
                    end
                    else
                    begin
                        c = inc;
                    end
                end
                sys_nxt.cnt[ch*tlsr_pkg::CNT_W +: tlsr_pkg::CNT_W] = c;

                // Critical flags: set wins over hysteresis clear
                // No consecutive count here; shutdown acts on the first result
                if (sOverCrit[ch])
                begin
                    sys_nxt.critFlags[ch] = 1'b1;
                end
                else if (sBelowCritHyst[ch])
                begin
                    sys_nxt.critFlags[ch] = 1'b0;
                end
            end
        end

        // Summaries track their flag registers
        sys_nxt.highSum = |sys_nxt.highFlags;
        sys_nxt.lowSum = |sys_nxt.lowFlags;
        sys_nxt.critSum = |sys_nxt.critFlags;

        // Event output: comparator mode ignores low flags; masked channels drop out
        if (comparatorMode)
        begin
            sys_nxt.eventActive = |(sys_nxt.highFlags & ~suppress);
        end
        else
        begin
            sys_nxt.eventActive = |((sys_nxt.highFlags | sys_nxt.lowFlags) & ~suppress);
        end
        // Shutdown sees every channel regardless of mask
        sys_nxt.shutActive = |sys_nxt.critFlags;

        // Only the averaging field is writable; everything else ignores writes
        // Identification writes land here and are dropped without a trace
        if (regWrEn && (regAddr == tlsr_pkg::ADDR_AVG_CFG))
        begin
            sys_nxt.avgCfg = regWrData[tlsr_pkg::AVG_LSB +: tlsr_pkg::AVG_W];
        end

        // Read data, registered; upper bits of flag registers are zero
        if (regRdEn)
        begin
            case (regAddr)
                tlsr_pkg::ADDR_OVER_HIGH: sys_nxt.rdData = {6'h00, sys_r.highFlags};
                tlsr_pkg::ADDR_UNDER_LOW: sys_nxt.rdData = {6'h00, sys_r.lowFlags};
                tlsr_pkg::ADDR_CRITICAL: sys_nxt.rdData = {6'h00, sys_r.critFlags};
                tlsr_pkg::ADDR_AVG_CFG: sys_nxt.rdData = {6'h00, sys_r.avgCfg};
                tlsr_pkg::ADDR_PART_ID: sys_nxt.rdData = PART_CODE;
                tlsr_pkg::ADDR_MAKER_ID: sys_nxt.rdData = MAKER_CODE;
                tlsr_pkg::ADDR_REVISION: sys_nxt.rdData = REV_SEL_B ? REV_CODE_B : REV_CODE_A;
                default: sys_nxt.rdData = tlsr_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // The conversion domain keeps running while ce is low; two results
    // arriving in one frozen stretch cancel out and leave no toggle edge
    // System-domain registers; clock enable freezes this domain
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sys_r <= '0;
        end
        else if (ce)
        begin
            sys_r <= sys_nxt;
        end
    end

    // Averaging decode for the external channel filter
    // Kept next to the flop; the filter itself sits in the conversion path
    always_comb
    begin
        case (sys_r.avgCfg)
            2'b00: extAvgLevel = tlsr_pkg::AVG_OFF;
            2'b01: extAvgLevel = tlsr_pkg::AVG_LEVEL1;
            2'b10: extAvgLevel = tlsr_pkg::AVG_LEVEL1;
            2'b11: extAvgLevel = tlsr_pkg::AVG_LEVEL2;
            default: extAvgLevel = tlsr_pkg::AVG_OFF;
        endcase
    end

    // Outputs straight from flops; pins are active low
    // Summaries are stored beside the flags, so both move on one edge
    assign regRdData = sys_r.rdData;
    assign eventOutN = ~sys_r.eventActive;
    assign shutdownOutN = ~sys_r.shutActive;
    assign highSummary = sys_r.highSum;
    assign lowSummary = sys_r.lowSum;
    assign critSummary = sys_r.critSum;

endmodule // temp_limit_status_regs

`default_nettype wire

// file: dv/tlsr_assertions.sv
// Checker: readback, summary and pin relations of the limit status bank
`timescale 1ns/1ps
`default_nettype none
module tlsr_assertions #(
    parameter logic [7:0] PART_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
    parameter logic [7:0] REV_CODE_A = 8'h11, // Arbitrary value
    parameter logic [7:0] REV_CODE_B = 8'h12, // Arbitrary value
    parameter bit REV_SEL_B = 1'b0
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [7:0] regRdData,
    input wire logic eventOutN,
    input wire logic shutdownOutN,
    input wire logic highSummary,
    input wire logic lowSummary,
    input wire logic critSummary,
    input wire tlsr_pkg::tlsr_avg_e extAvgLevel
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Read as taken by the bank; ce low means nothing is taken
    logic rdTake;
    assign rdTake = ce && regRdEn;
    chk_part_code: assert property (rdTake && regAddr == tlsr_pkg::ADDR_PART_ID
        |=> regRdData == PART_CODE) else $error("part code readback wrong");
    chk_maker_code: assert property (rdTake && regAddr == tlsr_pkg::ADDR_MAKER_ID
        |=> regRdData == MAKER_CODE) else $error("maker code readback wrong");
    chk_rev_code: assert property (rdTake && regAddr == tlsr_pkg::ADDR_REVISION
        |=> regRdData == (REV_SEL_B ? REV_CODE_B : REV_CODE_A)) else $error("revision wrong");
    chk_high_summary: assert property (rdTake && regAddr == tlsr_pkg::ADDR_OVER_HIGH
        |=> (regRdData[1:0] != 2'h0) == $past(highSummary)) else $error("high summary off");
    chk_low_summary: assert property (rdTake && regAddr == tlsr_pkg::ADDR_UNDER_LOW
        |=> (regRdData[1:0] != 2'h0) == $past(lowSummary)) else $error("low summary off");
    chk_crit_summary: assert property (rdTake && regAddr == tlsr_pkg::ADDR_CRITICAL
        |=> (regRdData[1:0] != 2'h0) == $past(critSummary)) else $error("crit summary off");
    chk_unused_zero: assert property (rdTake && regAddr inside {[8'h35:8'h37]}
        |=> regRdData[7:2] == 6'h00) else $error("unused flag bits not zero");
    chk_shutdown_crit: assert property (shutdownOutN == !critSummary)
        else $error("shutdown does not follow critical flags");
    chk_event_flag: assert property (!eventOutN |-> highSummary || lowSummary)
        else $error("event active without a flag");
    chk_avg_decode: assert property (rdTake && !regWrEn && regAddr == tlsr_pkg::ADDR_AVG_CFG
        |=> extAvgLevel == (regRdData[1:0] == 2'h0 ? tlsr_pkg::AVG_OFF :
        regRdData[1:0] == 2'h3 ? tlsr_pkg::AVG_LEVEL2 : tlsr_pkg::AVG_LEVEL1))
        else $error("averaging level decode wrong");
endmodule // tlsr_assertions
bind temp_limit_status_regs tlsr_assertions #(.PART_CODE(PART_CODE),
    .MAKER_CODE(MAKER_CODE), .REV_CODE_A(REV_CODE_A), .REV_CODE_B(REV_CODE_B),
    .REV_SEL_B(REV_SEL_B)) tlsr_assertions_i (.mclk, .rst, .ce, .regAddr, .regRdEn,
    .regWrEn, .regRdData, .eventOutN, .shutdownOutN, .highSummary, .lowSummary,
    .critSummary, .extAvgLevel);
`default_nettype wire

// file: dv/tlsr_conv_model.sv
// Conversion-side model: one measurement result per call on convClk
`timescale 1ns/1ps
`default_nettype none
module tlsr_conv_model (
    input wire logic convClk,
    output logic measValid,
    output logic [1:0] overHigh,
    output logic [1:0] underLow,
    output logic [1:0] overCrit,
    output logic [1:0] belowCritHyst,
    output logic [1:0] belowHighHyst
);
    // Idle state at time zero
    initial
    begin
        measValid = 1'b0;
        {overHigh, underLow, overCrit, belowCritHyst, belowHighHyst} = 10'h000;
    end
    // Lines are inverted after the pulse so stale values cannot pass for fresh
    task automatic measure(input logic [9:0] v);
        @(posedge convClk);
        #1;
        {overHigh, underLow, overCrit, belowCritHyst, belowHighHyst} = v;
        measValid = 1'b1;
        @(posedge convClk);
        #1;
        measValid = 1'b0;
        {overHigh, underLow, overCrit, belowCritHyst, belowHighHyst} = ~v;
        repeat (3) @(posedge convClk);
    endtask
endmodule // tlsr_conv_model
`default_nettype wire

// file: dv/temp_limit_status_regs_tb.sv
// Bench: register reads, random conversions, flag model compared at each result
`timescale 1ns/1ps
`default_nettype none
module temp_limit_status_regs_tb;
    localparam logic [7:0] PART = 8'h5A; // Arbitrary value
    localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value
    localparam logic [7:0] REV_B = 8'h27; // Arbitrary value
    localparam logic [2:0] CODES [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic mclk = 1'b0;
    logic rst, ce, regRdEn, regWrEn, cmpMode, extSup, intSup, convClk, convRst;
    logic measValid, eventOutN, shutdownOutN, highSummary, lowSummary, critSummary;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [2:0] cntSet;
    logic [1:0] overHigh, underLow, overCrit, belowCritHyst, belowHighHyst, hF, lF, cF;
    tlsr_pkg::tlsr_avg_e extAvgLevel;
    int n_mismatch, comparisons, seed, need;
    int cnt [2];
    temp_limit_status_regs #(.PART_CODE(PART), .MAKER_CODE(MAKER), .REV_CODE_B(REV_B),
        .REV_SEL_B(1'b1)) temp_limit_status_regs_i (.mclk, .rst, .ce, .regAddr, .regRdEn,
        .regWrEn, .regWrData, .regRdData, .comparatorMode(cmpMode),
        .eventCountSetting(cntSet), .extEventSuppress(extSup), .intEventSuppress(intSup),
        .convClk, .convRst, .measValid, .overHigh, .underLow, .overCrit, .belowCritHyst,
        .belowHighHyst, .eventOutN, .shutdownOutN, .highSummary, .lowSummary, .critSummary,
        .extAvgLevel);
    tlsr_conv_model tlsr_conv_model_i (.convClk, .measValid, .overHigh, .underLow,
        .overCrit, .belowCritHyst, .belowHighHyst);
    // System clock
    always #12.5 mclk = ~mclk;
    // Conversion clock, offset so its edges never line up with mclk
    initial
    begin
        convClk = 1'b0;
        #7;
        forever #62.5 convClk = ~convClk;
    end
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle strobe launched on a falling edge, so callers on convClk stay safe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        chk($sformatf("read %h", a), regRdData, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
    endtask
    task automatic chkOut();
        chk("highSummary", 8'(highSummary), 8'(|hF));
        chk("lowSummary", 8'(lowSummary), 8'(|lF));
        chk("critSummary", 8'(critSummary), 8'(|cF));
        chk("eventOutN", 8'(eventOutN),
            8'(~|((hF | (cmpMode ? 2'h0 : lF)) & ~{extSup, intSup})));
        chk("shutdownOutN", 8'(shutdownOutN), 8'(~|cF));
    endtask
    // Host acknowledges latched events by reading all three flag registers
    task automatic rdFlags();
        rd(tlsr_pkg::ADDR_OVER_HIGH, {6'h00, hF});
        if (!cmpMode) hF = 2'h0;
        rd(tlsr_pkg::ADDR_UNDER_LOW, {6'h00, lF});
        if (!cmpMode) lF = 2'h0;
        rd(tlsr_pkg::ADDR_CRITICAL, {6'h00, cF});
        chkOut();
    endtask
    // Random measurement, then the per-channel consecutive count model
    task automatic meas();
        logic [9:0] r;
        logic [1:0] hi, lo, oc, bc, bh;
        r = 10'($random(seed));
        hi = r[1:0];
        lo = r[3:2] & ~hi;
        oc = r[5:4];
        bc = r[7:6] & ~oc;
        bh = r[9:8] & ~hi;
        tlsr_conv_model_i.measure({hi, lo, oc, bc, bh});
        for (int c = 0; c < 2; c++)
        begin
            if (hi[c] || (lo[c] && !cmpMode))
            begin
                cnt[c]++;
                if (cnt[c] >= need)
                begin
                    hF[c] = hF[c] | hi[c];
                    lF[c] = lF[c] | lo[c];
                    if (!cmpMode) cnt[c] = 0;
                end
            end
            else cnt[c] = 0;
            if (cmpMode && bh[c]) hF[c] = 1'b0;
            if (oc[c]) cF[c] = 1'b1;
            else if (bc[c]) cF[c] = 1'b0;
        end
        if (cmpMode) lF = lo;
        chkOut();
    endtask
    // Watchdog far beyond the expected run of some 42 us
    initial
    begin
        #2000000;
        n_mismatch++;
        close_out();
    end
    // Main sequence: each mode with one count setting per count of one to four, after its own reset
    initial
    begin
        seed = 83;
        {rst, convRst, ce, regRdEn, regWrEn, cmpMode, extSup, intSup} = 8'hE0;
        {regAddr, regWrData, cntSet} = 19'h00000;
        for (int m = 0; m < 8; m++)
        begin
            @(negedge mclk);
            {rst, convRst} = 2'h3;
            cmpMode = m[2];
            cntSet = CODES[m[1:0]];
            need = m[1:0] + 1;
            {extSup, intSup} = 2'($random(seed));
            {hF, lF, cF} = 6'h00;
            cnt = '{0, 0};
            repeat (5) @(negedge mclk);
            {rst, convRst} = 2'h0;
            rdFlags();
            if (m == 0)
            begin
                rd(tlsr_pkg::ADDR_AVG_CFG, 8'h00);
                wr(tlsr_pkg::ADDR_PART_ID, ~PART);
                rd(tlsr_pkg::ADDR_PART_ID, PART);
                rd(tlsr_pkg::ADDR_MAKER_ID, MAKER);
                rd(tlsr_pkg::ADDR_REVISION, REV_B);
                rd(8'h50, 8'h00);
                wr(tlsr_pkg::ADDR_OVER_HIGH, 8'hFF);
                rd(tlsr_pkg::ADDR_OVER_HIGH, 8'h00);
                for (int v = 0; v < 4; v++)
                begin
                    wr(tlsr_pkg::ADDR_AVG_CFG, {6'h3F, 2'(v)});
                    rd(tlsr_pkg::ADDR_AVG_CFG, {6'h00, 2'(v)});
                    chk("extAvgLevel", 8'(extAvgLevel), v == 0 ? tlsr_pkg::AVG_OFF :
                        v == 3 ? tlsr_pkg::AVG_LEVEL2 : tlsr_pkg::AVG_LEVEL1);
                end
                // Write with ce low must be refused
                ce = 1'b0;
                wr(tlsr_pkg::ADDR_AVG_CFG, 8'h00);
                ce = 1'b1;
                rd(tlsr_pkg::ADDR_AVG_CFG, 8'h03);
            end
            for (int k = 0; k < 7; k++)
            begin
                meas();
                if ($random(seed) & 1) rdFlags();
            end
        end
        close_out();
    end
endmodule // temp_limit_status_regs_tb
`default_nettype wire
